// ===== logic/dfp_data_path_control.sv
// Data path control and status registers behind an Avalon-MM slave.
// Summary of operation
// - Wide odd count holds last byte for next.
// - Transfer enable gates SCSI acknowledges.
// - Transfer enable reads acknowledge; poll until zero.
// - Sync data-in with nonzero offset always enabled.
// - SCSI DMA enable gates block-to-FIFO moves.
// - DMA enables read acknowledge; wait for zero.
// - Host DMA clear pauses, keeping data and count.
// - Direction one is host to SCSI.
// - Direction acknowledge changes only with enables clear.
// - Flush drains FIFO to host, self clears.
// - Count zero or phase change flushes too.
// - Flush bit reads one while flush pending.
// - Flush during sequencer load accepts partial dword.
// - Pointer clear empties FIFO, latches byte offset.
// - One write sets enables, clear and direction.
// - Dword empty means read equals write address.
// - Master request pending while host needs bus.
// - Host done is count zero and last done.
// - Threshold bit reports programmed occupancy limit.
// - Full flag, and empty including holding registers.
// - Unused control and status bits read zero.
// - Host count write while enabled is refused.
`timescale 1ns/1ps
module dfp_data_path_control
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [dfp_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [dfp_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [dfp_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [1:0] host_addr_low,
    input wire dfp_pkg::dfp_path_in_t path_in,
    output dfp_pkg::dfp_path_out_t path_out,
    output logic illegal_seq_address_error
);
    import dfp_pkg::*;

    // All state of the block in one record.
    typedef struct packed {
        logic bus_ack;                    // Answer cycle of the current access.
        logic [DATA_W-1:0] rdata;         // Registered read data.
        logic wide_odd;                   // Wide odd hold enable.
        logic bus_xfer_en;                // SCSI transfer enable request.
        logic bus_dma_en;                 // SCSI DMA enable request.
        logic host_dma_en;                // Host DMA enable request.
        logic dir_req;                    // Direction as written.
        logic dir_ack;                    // Direction in effect.
        logic drain;                      // Flush pending or running.
        logic partial;                    // Partial double word accept.
        logic hold_byte;                  // Odd byte held in the SCSI block.
        logic [PTR_W-1:0] wr_ptr;         // FIFO write address with rollover bit.
        logic [PTR_W-1:0] rd_ptr;         // FIFO read address with rollover bit.
        logic [1:0] byte_offset;          // Offset from the host address.
        logic [HOST_BYTE_COUNT_W-1:0] host_count;    // Host byte count.
        logic host_done;                  // Host transfer complete.
        logic master_request_line_pend;                  // Master request pending.
        logic [THR_W-1:0] thr_limit;      // Threshold limit code.
        logic ill_addr;                   // Illegal sequencer address flag.
    } dfp_state_t;

    dfp_state_t state_q;
    dfp_state_t state_d;

    logic bus_xfer_ack;                   // Acknowledge of the SCSI transfer enable.
    logic bus_dma_ack;                    // Acknowledge of the SCSI DMA enable.
    logic host_dma_ack;                   // Acknowledge of the host DMA enable.
    logic [9:0] idx;                      // Register index from the byte address.
    logic req;                            // Any bus request.
    logic wr_take;                        // Write takes effect this edge.
    logic [7:0] ctrl_rd;                  // Control register read view.
    logic [7:0] stat_rd;                  // Status register read view.
    logic [PTR_W-1:0] occupancy;          // Double words held in the FIFO.
    logic dword_eq;                       // Read and write addresses equal.
    logic fifo_full;                      // FIFO full.
    logic fifo_empty;                     // FIFO and holding registers empty.
    logic thr_met;                        // Occupancy reached the threshold.
    logic [PTR_W-1:0] thr_level;          // Threshold in double words.

    // The three enable acknowledges share one small module.
    dfp_enable_ack u_bus_xfer_ack
    (
        .clk(clk),
        .rst(rst),
        .enable(state_q.bus_xfer_en),
        .path_busy(path_in.bus_xfer_busy),
        .ack(bus_xfer_ack)
    );

    dfp_enable_ack u_bus_dma_ack
    (
        .clk(clk),
        .rst(rst),
        .enable(state_q.bus_dma_en),
        .path_busy(path_in.bus_dma_busy),
        .ack(bus_dma_ack)
    );

    dfp_enable_ack u_host_dma_ack
    (
        .clk(clk),
        .rst(rst),
        .enable(state_q.host_dma_en),
        .path_busy(path_in.host_dma_busy),
        .ack(host_dma_ack)
    );

    // Bus decode: every access waits one cycle, then answers.
    assign idx = avs_address[ADDR_W-1:2];
    assign req = avs_read | avs_write;
    assign wr_take = avs_write & state_q.bus_ack;
    assign avs_waitrequest = req & ~state_q.bus_ack;
    assign avs_readdata = state_q.rdata;

    // FIFO status derived from the two pointers.
    assign occupancy = state_q.wr_ptr - state_q.rd_ptr;
    assign dword_eq = (state_q.wr_ptr == state_q.rd_ptr);
    assign fifo_full = (state_q.wr_ptr[PTR_W-2:0] == state_q.rd_ptr[PTR_W-2:0])
        & (state_q.wr_ptr[PTR_W-1] != state_q.rd_ptr[PTR_W-1]);
    assign fifo_empty = dword_eq & path_in.holding_empty;
    assign thr_level = PTR_W'({1'b0, state_q.thr_limit} + 3'h1) * THR_STEP;
    assign thr_met = fifo_full | (occupancy >= thr_level);

    // Read views; bit 7 of control and bits 7 and 6 of status stay zero.
    always_comb
    begin
        ctrl_rd = CTRL_RESET;
        ctrl_rd[CTRL_WIDE_ODD] = state_q.wide_odd;
        ctrl_rd[CTRL_BUS_XFER] = bus_xfer_ack;
        ctrl_rd[CTRL_BUS_DMA] = bus_dma_ack;
        ctrl_rd[CTRL_HOST_DMA] = host_dma_ack;
        ctrl_rd[CTRL_DIR] = state_q.dir_ack;
        ctrl_rd[CTRL_DRAIN] = state_q.drain;
        ctrl_rd[CTRL_PTR_CLEAR] = 1'b0; // Pointer clear is self clearing.
        stat_rd = CTRL_RESET;
        stat_rd[STAT_DWORD_EQ] = dword_eq;
        stat_rd[STAT_MASTER_REQUEST_LINE] = state_q.master_request_line_pend;
        stat_rd[STAT_HOST_XFER_DONE] = state_q.host_done;
        stat_rd[STAT_THRESH] = thr_met;
        stat_rd[STAT_FULL] = fifo_full;
        stat_rd[STAT_EMPTY] = fifo_empty;
    end

    // Next state of the whole block.
    always_comb
    begin
        logic ctrl_wr;
        logic cnt_wr;
        logic ptr_clear;
        logic sw_drain;
        logic hw_drain;
        logic [HOST_BYTE_COUNT_W-1:0] cnt_new;
        ctrl_wr = 1'b0;
        cnt_wr = 1'b0;
        ptr_clear = 1'b0;
        sw_drain = 1'b0;
        hw_drain = 1'b0;
        cnt_new = state_q.host_count;
        state_d = state_q;

        // The answer cycle lasts one clock; read data is captured beforehand.
        state_d.bus_ack = req & ~state_q.bus_ack;
        if (avs_read & ~state_q.bus_ack)
        begin
            case (idx)
                IDX_CTRL: state_d.rdata = {24'h000000, ctrl_rd};
                IDX_STATUS: state_d.rdata = {24'h000000, stat_rd};
                IDX_ERROR: state_d.rdata = DATA_W'({state_q.ill_addr, 1'b0});
                IDX_HOST_COUNT: state_d.rdata = {8'h00, state_q.host_count};
                IDX_THRESH: state_d.rdata = DATA_W'(state_q.thr_limit);
                default: state_d.rdata = '0; // Unmapped addresses read zero.
            endcase
        end

        // Register writes at the edge where waitrequest is low.
        if (wr_take)
        begin
            case (idx)
                IDX_CTRL:
                begin
                    ctrl_wr = avs_byteenable[0];
                end
                IDX_HOST_COUNT:
                begin
                    // Changing the count under a live host DMA is an error.
                    if (state_q.host_dma_en | host_dma_ack)
                    begin
                        state_d.ill_addr = 1'b1;
                    end
                    else
                    begin
                        cnt_wr = 1'b1;
                    end
                end
                IDX_ERROR:
                begin
                    // Write one to clear the error flag.
                    if (avs_byteenable[0] & avs_writedata[ERR_ILL_SEQ_ADDR])
                    begin
                        state_d.ill_addr = 1'b0;
                    end
                end
                IDX_THRESH:
                begin
                    if (avs_byteenable[0])
                    begin
                        state_d.thr_limit = avs_writedata[THR_W-1:0];
                    end
                end
                default:
                begin
                    // Writes to unmapped addresses are ignored.
                end
            endcase
        end

        // A single control write may carry enables, clear and direction at once.
        if (ctrl_wr)
        begin
            state_d.wide_odd = avs_writedata[CTRL_WIDE_ODD];
            state_d.bus_xfer_en = avs_writedata[CTRL_BUS_XFER];
            state_d.bus_dma_en = avs_writedata[CTRL_BUS_DMA];
            state_d.host_dma_en = avs_writedata[CTRL_HOST_DMA];
            state_d.dir_req = avs_writedata[CTRL_DIR];
            ptr_clear = avs_writedata[CTRL_PTR_CLEAR];
            sw_drain = avs_writedata[CTRL_DRAIN];
        end

        // Direction takes effect only while every enable and acknowledge is clear.
        if (~(state_q.bus_xfer_en | state_q.bus_dma_en | state_q.host_dma_en
            | bus_xfer_ack | bus_dma_ack | host_dma_ack))
        begin
            state_d.dir_ack = state_q.dir_req;
        end

        // Pointer movement; a pointer clear overrides any movement.
        if (path_in.fifo_push)
        begin
            state_d.wr_ptr = state_q.wr_ptr + PTR_W'(1);
        end
        if (path_in.fifo_pop)
        begin
            state_d.rd_ptr = state_q.rd_ptr + PTR_W'(1);
        end
        if (ptr_clear)
        begin
            state_d.wr_ptr = PTR_RESET;
            state_d.rd_ptr = PTR_RESET;
            state_d.byte_offset = host_addr_low;
        end

        // Firmware flush works only when reading from SCSI and data is present;
        // during a sequencer load it instead asks for a partial double word.
        hw_drain = path_in.bus_transfer_count_zero | path_in.phase_change;
        if (path_in.drain_complete)
        begin
            state_d.drain = 1'b0;
            state_d.partial = 1'b0;
        end
        // New requests win over a completion in the same cycle.
        if ((sw_drain & ~state_q.dir_ack & ~fifo_empty) | hw_drain)
        begin
            state_d.drain = 1'b1;
        end
        if (sw_drain & path_in.seq_fifo_writing)
        begin
            state_d.partial = 1'b1;
            state_d.drain = 1'b1;
        end

        // Host count: written value or decrement; it survives a DMA pause.
        if (cnt_wr)
        begin
            if (avs_byteenable[0])
            begin
                cnt_new[7:0] = avs_writedata[7:0];
            end
            if (avs_byteenable[1])
            begin
                cnt_new[15:8] = avs_writedata[15:8];
            end
            if (avs_byteenable[2])
            begin
                cnt_new[23:16] = avs_writedata[23:16];
            end
            state_d.host_count = cnt_new;
        end
        else if (path_in.host_count_dec & (state_q.host_count != HOST_BYTE_COUNT_RESET))
        begin
            state_d.host_count = state_q.host_count
                - HOST_BYTE_COUNT_W'(path_in.host_dec_bytes);
        end

        // Host done sets on zero count with the last transfer done; a nonzero
        // count store clears it.
        if (cnt_wr & (cnt_new != HOST_BYTE_COUNT_RESET))
        begin
            state_d.host_done = 1'b0;
        end
        else if ((state_q.host_count == HOST_BYTE_COUNT_RESET) & path_in.host_last_done)
        begin
            state_d.host_done = 1'b1;
        end

        // Master request pending follows the host need, dropped on done or clear.
        state_d.master_request_line_pend = path_in.host_xfer_needed & host_dma_ack & state_q.host_dma_en
            & ~state_q.host_done & ~ptr_clear;

        // Wide odd hold keeps the final byte until the next first byte.
        if (state_q.wide_odd & path_in.wide_xfer & path_in.odd_last_byte)
        begin
            state_d.hold_byte = 1'b1;
        end
        else if (path_in.next_first_byte)
        begin
            state_d.hold_byte = 1'b0;
        end
    end

    // State register.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_q <= '0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // Path controls: enable requests gate new cycles at once when cleared.
    always_comb
    begin
        path_out.bus_xfer_allow = state_q.bus_xfer_en
            | ((path_in.sync_rate_offset != RATE_ZERO) & path_in.data_in_phase);
        path_out.bus_dma_allow = state_q.bus_dma_en;
        path_out.host_dma_allow = state_q.host_dma_en;
        path_out.dir_acknowledge = state_q.dir_ack;
        path_out.buffer_drain_request = state_q.drain;
        path_out.partial_dword_accept = state_q.partial;
        path_out.hold_last_byte = state_q.hold_byte;
        path_out.master_request_line = state_q.master_request_line_pend;
        path_out.byte_offset = state_q.byte_offset;
    end

    assign illegal_seq_address_error = state_q.ill_addr;
endmodule // dfp_data_path_control

// ===== logic/dfp_enable_ack.sv
// One enable bit with its acknowledge that falls only after the path goes idle.
`timescale 1ns/1ps
module dfp_enable_ack
(
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic path_busy,
    output logic ack
);
    import dfp_pkg::*;

    // All state of this module.
    typedef struct packed {
        logic ack;
    } dfp_ena_state_t;

    dfp_ena_state_t state_q;
    dfp_ena_state_t state_d;

    // The acknowledge follows a set on the next clock but holds after a clear until the
    // cycle in progress has ended, so a zero readback means idle.
    always_comb
    begin
        state_d = state_q;
        state_d.ack = enable | (state_q.ack & path_busy);
    end

    // State register.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_q <= '0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign ack = state_q.ack;
endmodule // dfp_enable_ack

// ===== logic/dfp_pkg.sv
// Package with register map, field layout and carrier types of the data path control block.
package dfp_pkg;

    // Avalon-MM byte address width and data width.
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [9:0] IDX_ERROR = 10'h092;
    localparam logic [9:0] IDX_CTRL = 10'h093;
    localparam logic [9:0] IDX_STATUS = 10'h094;
    localparam logic [9:0] IDX_HOST_COUNT = 10'h0A0;
    localparam logic [9:0] IDX_THRESH = 10'h0A1;

    // Control register field positions.
    localparam int CTRL_WIDE_ODD = 6;
    localparam int CTRL_BUS_XFER = 5;
    localparam int CTRL_BUS_DMA = 4;
    localparam int CTRL_HOST_DMA = 3;
    localparam int CTRL_DIR = 2;
    localparam int CTRL_DRAIN = 1;
    localparam int CTRL_PTR_CLEAR = 0;

    // Status register field positions.
    localparam int STAT_DWORD_EQ = 5;
    localparam int STAT_MASTER_REQUEST_LINE = 4;
    localparam int STAT_HOST_XFER_DONE = 3;
    localparam int STAT_THRESH = 2;
    localparam int STAT_FULL = 1;
    localparam int STAT_EMPTY = 0;

    // Error register field position of the illegal sequencer address flag.
    localparam int ERR_ILL_SEQ_ADDR = 1;

    // Widths of the pointer, host count and threshold fields.
    localparam int PTR_W = 7;
    localparam int HOST_BYTE_COUNT_W = 24;
    localparam int THR_W = 2;
    localparam int RATE_W = 4;

    // Reset values.
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [PTR_W-1:0] PTR_RESET = 7'h00;
    localparam logic [HOST_BYTE_COUNT_W-1:0] HOST_BYTE_COUNT_RESET = 24'h000000;
    localparam logic [THR_W-1:0] THR_RESET = 2'h0;
    localparam logic [RATE_W-1:0] RATE_ZERO = 4'h0;

    // Threshold step in double words per limit code.
    localparam logic [PTR_W-1:0] THR_STEP = 7'h10;

    // Inputs from the surrounding data path, all synchronous levels or one-cycle pulses.
    typedef struct packed {
        logic bus_xfer_busy;          // SCSI bus transfer cycle still running.
        logic bus_dma_busy;           // SCSI block to FIFO cycle still running.
        logic host_dma_busy;          // Host bus cycle still running.
        logic [RATE_W-1:0] sync_rate_offset; // Programmed synchronous offset.
        logic data_in_phase;          // SCSI bus is in data-in phase.
        logic phase_change;           // Pulse: SCSI bus phase changed.
        logic bus_transfer_count_zero; // Pulse: SCSI transfer count reached zero.
        logic drain_complete;         // Pulse: flush finished.
        logic fifo_push;              // Pulse: one double word written into the FIFO.
        logic fifo_pop;               // Pulse: one double word read from the FIFO.
        logic holding_empty;          // All data holding registers are empty.
        logic seq_fifo_writing;       // Sequencer is loading the FIFO.
        logic host_xfer_needed;       // Host logic needs a host bus transfer.
        logic host_count_dec;         // Pulse: host count decrements.
        logic [2:0] host_dec_bytes;   // Bytes moved by that decrement.
        logic host_last_done;         // Last host transfer has completed.
        logic wide_xfer;              // 16-bit SCSI transfer in use.
        logic odd_last_byte;          // Pulse: odd final byte of a wide transfer.
        logic next_first_byte;        // Pulse: first byte of the next transfer.
    } dfp_path_in_t;

    // Controls driven to the surrounding data path.
    typedef struct packed {
        logic bus_xfer_allow;         // SCSI acknowledges may be issued.
        logic bus_dma_allow;          // SCSI block to FIFO moves allowed.
        logic host_dma_allow;         // Host bus transfers allowed.
        logic dir_acknowledge;        // 1: host to SCSI, 0: SCSI to host.
        logic buffer_drain_request;   // Flush pending or running.
        logic partial_dword_accept;   // Accept a partial double word load.
        logic hold_last_byte;         // Keep the odd final byte in the SCSI block.
        logic master_request_line;    // Request host bus mastership.
        logic [1:0] byte_offset;      // Byte offset latched at pointer clear.
    } dfp_path_out_t;

endpackage

// ===== test/data_fifo_path_control_tb.sv
// Self-checking bench of the data path control block.
`timescale 1ns/1ps
module data_fifo_path_control_tb;
    import dfp_pkg::*;
    logic clk = 0, rst = 1, rd_q = 0, wr_q = 0, wait_r, ill;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata_w, rdata;
    logic [3:0] linger = 4'h8; // Tail of each path cycle after its allow drops.
    logic [2:0] busy;
    dfp_path_in_t p = '0, pin; // Bench-driven path inputs; pin adds the model's busy.
    dfp_path_out_t po;
    int err_total = 0, comparisons = 0;
    initial forever #25 clk = ~clk;
    always_comb
    begin
        pin = p;
        {pin.bus_xfer_busy, pin.bus_dma_busy, pin.host_dma_busy} = busy;
    end
    dfp_data_path_control dut (.clk(clk), .rst(rst), .avs_address(addr), .avs_read(rd_q),
        .avs_write(wr_q), .avs_writedata(wdata), .avs_byteenable(4'hF), .avs_readdata(rdata_w),
        .avs_waitrequest(wait_r), .host_addr_low(2'h0), .path_in(pin), .path_out(po),
        .illegal_seq_address_error(ill));
    dfp_path_model model (.clk(clk), .rst(rst), .linger(linger), .path_out(po), .busy(busy));
    task automatic test_done();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One Avalon cycle held until waitrequest is seen low; read data land in rdata.
    task automatic bus(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        addr <= {idx, 2'h0};
        wr_q <= wr;
        rd_q <= !wr;
        wdata <= wd;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wait_r !== 1'b0 && n < 20);
        rdata = rdata_w;
        if (n >= 20)
        begin
            err_total++;
            test_done();
        end
        wr_q <= 1'b0;
        rd_q <= 1'b0;
    endtask
    // Waits a bounded time for the direction acknowledge, then judges it.
    task automatic wait_dir(input logic v);
        for (int i = 0; i < 40 && po.dir_acknowledge !== v; i++)
            @(posedge clk);
        chk(po.dir_acknowledge, v);
    endtask
    task automatic s_ack();
        bus(1, IDX_CTRL, 32'h38);
        bus(0, IDX_CTRL, 0);
        chk(rdata[5:3], 3'h7);
        bus(1, IDX_CTRL, 32'h0);
        bus(0, IDX_CTRL, 0);
        chk(rdata[3], 1'b1);
        for (int i = 0; i < 20 && rdata[5:3] !== 3'h0; i++)
            bus(0, IDX_CTRL, 0);
        chk(rdata[5:3], 3'h0);
    endtask
    task automatic s_dir();
        bus(1, IDX_CTRL, 32'h0C);
        repeat (4) @(posedge clk);
        chk(po.dir_acknowledge, 1'b0);
        bus(1, IDX_CTRL, 32'h04);
        wait_dir(1'b1);
        bus(1, IDX_CTRL, 32'h00);
        wait_dir(1'b0);
    endtask
    task automatic s_flush();
        p.fifo_push <= 1'b1;
        @(posedge clk);
        p.fifo_push <= 1'b0;
        bus(1, IDX_CTRL, 32'h02);
        bus(0, IDX_CTRL, 0);
        chk(rdata[1], 1'b1);
        p.drain_complete <= 1'b1;
        @(posedge clk);
        p.drain_complete <= 1'b0;
        bus(0, IDX_CTRL, 0);
        chk(rdata[1], 1'b0);
        p.phase_change <= 1'b1;
        @(posedge clk);
        p.phase_change <= 1'b0;
        bus(0, IDX_CTRL, 0);
        chk(rdata[1], 1'b1);
        p.drain_complete <= 1'b1;
        @(posedge clk);
        p.drain_complete <= 1'b0;
    endtask
    task automatic s_full();
        p.fifo_push <= 1'b1;
        repeat (63) @(posedge clk);
        p.fifo_push <= 1'b0;
        bus(0, IDX_STATUS, 0);
        chk(rdata[7:0] & 8'hC3, 8'h02);
        bus(1, IDX_CTRL, 32'h01);
        bus(0, IDX_STATUS, 0);
        chk({rdata[7:5], rdata[1:0]}, 5'h05);
        bus(1, IDX_CTRL, 32'h02);
        bus(0, IDX_CTRL, 0);
        chk(rdata[1], 1'b0);
    endtask
    task automatic s_count();
        p.host_last_done <= 1'b1;
        bus(1, IDX_CTRL, 32'h08);
        bus(1, IDX_HOST_COUNT, 32'h5);
        bus(0, IDX_ERROR, 0);
        chk(rdata[1], 1'b1);
        chk(ill, 1'b1);
        bus(0, IDX_STATUS, 0);
        chk(rdata[3], 1'b1);
        bus(1, IDX_CTRL, 32'h00);
        bus(1, IDX_ERROR, 32'h2);
        for (int i = 0; i < 20 && busy !== 3'h0; i++)
            @(posedge clk);
        bus(1, IDX_HOST_COUNT, 32'h5);
        bus(0, IDX_STATUS, 0);
        chk(rdata[3], 1'b0);
    endtask
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        p.holding_empty <= 1'b1;
        bus(0, IDX_CTRL, 0);
        chk(rdata, 32'h0);
        bus(0, 10'h3FF, 0);
        chk(rdata, 32'h0);
        s_ack();
        s_dir();
        s_flush();
        s_full();
        s_count();
        bus(1, IDX_CTRL, 32'h48);
        p.sync_rate_offset <= 4'h3;
        p.data_in_phase <= 1'b1;
        p.wide_xfer <= 1'b1;
        p.odd_last_byte <= 1'b1;
        repeat (2) @(posedge clk);
        chk(po.bus_xfer_allow, 1'b1);
        chk(po.hold_last_byte, 1'b1);
        test_done();
    end
endmodule // data_fifo_path_control_tb

// ===== test/dfp_data_path_control_monitor.sv
// Checker of the data path control block at its ports.
`timescale 1ns/1ps
module dfp_data_path_control_monitor
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [dfp_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_write,
    input wire logic avs_read,
    input wire logic [dfp_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [dfp_pkg::DATA_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire dfp_pkg::dfp_path_in_t path_in,
    input wire dfp_pkg::dfp_path_out_t path_out,
    input wire logic illegal_seq_address_error
);
    import dfp_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic done_w; // A write completes in this cycle.
    assign done_w = avs_write && !avs_waitrequest;
    property p_ctrl;
        done_w && avs_address[11:2] == IDX_CTRL |=>
            {path_out.bus_dma_allow, path_out.host_dma_allow} == $past(avs_writedata[4:3]);
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("dma allows differ from control write");
    property p_dir;
        $changed(path_out.dir_acknowledge) |->
            $past(!path_out.bus_dma_allow && !path_out.host_dma_allow);
    endproperty
    a_dir: assert property (p_dir) else $error("direction moved while enabled");
    property p_sync;
        path_in.sync_rate_offset != RATE_ZERO && path_in.data_in_phase |-> path_out.bus_xfer_allow;
    endproperty
    a_sync: assert property (p_sync) else $error("sync data-in not allowed");
    property p_phase;
        path_in.phase_change |=> path_out.buffer_drain_request;
    endproperty
    a_phase: assert property (p_phase) else $error("phase change did not flush");
    property p_drain;
        $fell(path_out.buffer_drain_request) |-> $past(path_in.drain_complete);
    endproperty
    a_drain: assert property (p_drain) else $error("flush flag fell early");
    property p_ill;
        done_w && avs_address[11:2] == IDX_HOST_COUNT && path_out.host_dma_allow |=>
            illegal_seq_address_error;
    endproperty
    a_ill: assert property (p_ill) else $error("illegal count write not flagged");
    property p_master_request_line;
        !path_in.host_xfer_needed |=> !path_out.master_request_line;
    endproperty
    a_master_request_line: assert property (p_master_request_line) else $error("request without need");
    property p_unused;
        avs_read && !avs_waitrequest && avs_address[11:2] == IDX_STATUS |-> avs_readdata[7:6] == 2'h0;
    endproperty
    a_unused: assert property (p_unused) else $error("unused status bits set");
    c_ill: cover property (p_ill);
    c_phase: cover property (path_in.phase_change);
    c_dir: cover property ($changed(path_out.dir_acknowledge));
endmodule // dfp_data_path_control_monitor
bind dfp_data_path_control dfp_data_path_control_monitor u_mon (.clk(clk), .rst(rst),
    .avs_address(avs_address), .avs_write(avs_write), .avs_read(avs_read),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .path_in(path_in), .path_out(path_out),
    .illegal_seq_address_error(illegal_seq_address_error));

// ===== test/dfp_path_model.sv
// Data path model: each path stays busy for a while after its allow drops.
`timescale 1ns/1ps
module dfp_path_model
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] linger,
    input wire dfp_pkg::dfp_path_out_t path_out,
    output logic [2:0] busy
);
    import dfp_pkg::*;
    logic [2:0] allow; // Allows of SCSI bus, SCSI DMA and host paths.
    logic [3:0] cnt_q [3]; // Remaining cycles of the cycle in flight.
    assign allow = {path_out.bus_xfer_allow, path_out.bus_dma_allow, path_out.host_dma_allow};
    // A cycle in flight ends only after the allow is gone, never at once.
    always_ff @(posedge clk)
    begin
        for (int i = 0; i < 3; i++)
        begin
            if (rst)
                cnt_q[i] <= 4'h0;
            else if (allow[i])
                cnt_q[i] <= linger;
            else if (cnt_q[i] != 4'h0)
                cnt_q[i] <= cnt_q[i] - 4'h1;
        end
    end
    // Busy covers the allow itself and the lingering tail.
    always_comb
    begin
        for (int i = 0; i < 3; i++)
            busy[i] = allow[i] || (cnt_q[i] != 4'h0);
    end
endmodule // dfp_path_model
